// ### rtl/adcsc_pkg.sv
`default_nettype none
package adcsc_pkg;
    localparam logic [1:0] ADCSC_ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADCSC_ADDR_RES  = 2'h1;
    localparam logic [1:0] ADCSC_ADDR_ANS  = 2'h2;
    localparam logic [1:0] ADCSC_ADDR_IRQ  = 2'h3;
    localparam int CTRL_ON  = 0;
    localparam int CTRL_GO  = 1;
    localparam int CTRL_CHS = 2;
    localparam int CTRL_CKS = 6;
    localparam logic [7:0] CTRL_RESET = 8'hfc;
    localparam logic [7:0] ANS_RESET  = 8'hff;
    localparam logic [1:0] CKS_DIV16  = 2'h0;
    localparam logic [1:0] CKS_DIV8   = 2'h1;
    localparam logic [1:0] CKS_DIV4   = 2'h2;
    localparam logic [3:0] DIV16_TOP  = 4'hf;
    localparam logic [3:0] DIV8_TOP   = 4'h7;
    localparam logic [3:0] DIV4_TOP   = 4'h3;
    localparam logic [3:0] SHIFTS     = 4'h9;
    typedef enum logic [2:0] {
        ADCSC_IDLE = 3'h1,
        ADCSC_CONV = 3'h2,
        ADCSC_LAST = 3'h4
    } adcsc_state_t;
endpackage : adcsc_pkg
`default_nettype wire

// ### rtl/adcsc_div.sv
`default_nettype none
// Tick generator: one pulse per conversion bit period
module adcsc_div
    import adcsc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    // Control
    input  wire logic       run_in,
    input  wire logic [1:0] cks_in,
    input  wire logic       osc_tick_in,
    // Tick
    output logic            tick_out
);
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] top;
    logic       adv;
    always_comb begin
        case (cks_in)
            CKS_DIV16: top = DIV16_TOP;
            CKS_DIV8:  top = DIV8_TOP;
            CKS_DIV4:  top = DIV4_TOP;
            default:   top = DIV4_TOP;
        endcase
        // Select 11 counts internal oscillator ticks instead
        adv = (cks_in == 2'h3) ? osc_tick_in : 1'b1;
        cnt_d = cnt_q;
        if (!run_in)
            cnt_d = 4'h0;
        else if (adv)
            cnt_d = (cnt_q == top) ? 4'h0 : cnt_q + 4'h1;
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_d;
    end
    assign tick_out = run_in && adv && (cnt_q == top);
endmodule // adcsc_div
`default_nettype wire

// ### rtl/adcsc_top.sv
`default_nettype none
module adcsc_top
    import adcsc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    // Register port
    input  wire logic [1:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Device power state
    input  wire logic       sleep_in,
    input  wire logic       wake_in,
    input  wire logic       osc_tick_in,
    // Analog side
    input  wire logic       comp_in,
    output logic      [3:0] chan_out,
    output logic      [7:0] ans_out,
    output logic            conv_on_out,
    // Interrupt
    output logic            irq_out
);
    import adcsc_pkg::*;

    adcsc_state_t st_q, st_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] res_q, res_d;
    logic [7:0] ans_q, ans_d;
    logic [3:0] chan_q, chan_d;
    logic [3:0] nsh_q, nsh_d;
    logic       done_q, done_d, mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic [2:0] cs_q;
    logic       comp_s;
    logic       tick;
    logic       busy;
    logic [2:0] bit_pos;

    // Comparator is asynchronous: three stages, second and third agree
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cs_q   <= 3'h0;
            comp_s <= 1'b0;
        end else begin
            cs_q <= {cs_q[1:0], comp_in};
            if (cs_q[1] == cs_q[2])
                comp_s <= cs_q[2];
        end
    end

    assign busy = (st_q != ADCSC_IDLE);
    // Bit resolved on this tick, MSB on the second tick
    assign bit_pos = 3'(SHIFTS - 4'h1 - nsh_q);

    adcsc_div u_div (
        .ref_clk_in  (ref_clk_in),
        .reset_n_in  (reset_n_in),
        .run_in      (busy && !sleep_in),
        .cks_in      (ctrl_q[CTRL_CKS+:2]),
        .osc_tick_in (osc_tick_in),
        .tick_out    (tick)
    );

    always_comb begin
        st_d    = st_q;
        ctrl_d  = ctrl_q;
        res_d   = res_q;
        ans_d   = ans_q;
        chan_d  = chan_q;
        nsh_d   = nsh_q;
        done_d  = done_q;
        mask_d  = mask_q;
        rdata_d = 8'h0;
        if (wr_in && addr_in == ADCSC_ADDR_CTRL) begin
            ctrl_d = wdata_in;
            // Go only sticks when converter stays on
            if (!wdata_in[CTRL_ON])
                ctrl_d[CTRL_GO] = 1'b0;
        end
        if (wr_in && addr_in == ADCSC_ADDR_RES)
            res_d = wdata_in;
        if (wr_in && addr_in == ADCSC_ADDR_ANS)
            ans_d = wdata_in;
        if (wr_in && addr_in == ADCSC_ADDR_IRQ) begin
            mask_d = wdata_in[1];
            if (wdata_in[0])
                done_d = 1'b0;
        end
        if (!busy)
            chan_d = ctrl_d[CTRL_CHS+:4];
        case (st_q)
            ADCSC_IDLE: begin
                if (ctrl_d[CTRL_GO] && !ctrl_q[CTRL_GO] && !sleep_in) begin
                    res_d  = 8'h0;
                    nsh_d  = 4'h0;
                    chan_d = ctrl_d[CTRL_CHS+:4];
                    st_d   = ADCSC_CONV;
                end
            end
            ADCSC_CONV, ADCSC_LAST: begin
                if (!ctrl_d[CTRL_GO]) begin
                    st_d = ADCSC_IDLE;
                end else if (tick) begin
                    nsh_d = nsh_q + 4'h1;
                    // Marker shows how many bits a cut conversion kept
                    if (nsh_q == 4'h0)
                        res_d[$left(res_d)] = 1'b1;
                    else begin
                        res_d[bit_pos] = comp_s;
                        if (bit_pos != 3'h0)
                            res_d[bit_pos - 3'h1] = 1'b1;
                    end
                    if (nsh_d == SHIFTS) begin
                        ctrl_d[CTRL_GO] = 1'b0;
                        done_d = 1'b1;
                        st_d   = ADCSC_IDLE;
                        chan_d = ctrl_d[CTRL_CHS+:4];
                    end else if (nsh_d == SHIFTS - 4'h1)
                        st_d = ADCSC_LAST;
                end
            end
            default: st_d = ADCSC_IDLE;
        endcase
        if (sleep_in) begin
            ctrl_d = CTRL_RESET;
            chan_d = ctrl_d[CTRL_CHS+:4];
            st_d   = ADCSC_IDLE;
        end
        if (wake_in) begin
            ctrl_d = CTRL_RESET;
            ans_d  = ANS_RESET;
            chan_d = ctrl_d[CTRL_CHS+:4];
            st_d   = ADCSC_IDLE;
        end
        if (rd_in) begin
            case (addr_in)
                ADCSC_ADDR_CTRL: rdata_d = ctrl_q;
                ADCSC_ADDR_RES:  rdata_d = res_q;
                ADCSC_ADDR_ANS:  rdata_d = ans_q;
                default:         rdata_d = {6'h0, mask_q, done_q};
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q    <= ADCSC_IDLE;
            ctrl_q  <= CTRL_RESET;
            res_q   <= 8'h0;
            ans_q   <= ANS_RESET;
            chan_q  <= 4'hf;
            nsh_q   <= 4'h0;
            done_q  <= 1'b0;
            mask_q  <= 1'b0;
            rdata_q <= 8'h0;
        end else begin
            st_q    <= st_d;
            ctrl_q  <= ctrl_d;
            res_q   <= res_d;
            ans_q   <= ans_d;
            chan_q  <= chan_d;
            nsh_q   <= nsh_d;
            done_q  <= done_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out   = rdata_q;
    assign chan_out    = chan_q;
    assign ans_out     = ans_q;
    assign conv_on_out = ctrl_q[CTRL_ON];
    assign irq_out     = done_q && mask_q;

    a_sleep_clears: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        sleep_in && !wake_in |=> ctrl_q == CTRL_RESET && st_q == ADCSC_IDLE)
        else $error("sleep did not force control defaults");
    a_go_needs_on: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        ctrl_q[CTRL_GO] |-> ctrl_q[CTRL_ON])
        else $error("go set while converter off");
    a_no_sleep_prog: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        sleep_in |-> !tick)
        else $error("conversion advanced in sleep");
    a_done_clears_go: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        $rose(done_q) |-> !ctrl_q[CTRL_GO])
        else $error("done without go cleared");
    a_chan_stable: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        busy && $past(busy) && !sleep_in && !wake_in
            |-> $stable(chan_q))
        else $error("channel changed mid conversion");
    a_abort_keeps: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        busy && wr_in && addr_in == ADCSC_ADDR_CTRL && !wdata_in[CTRL_GO]
            && !sleep_in && !wake_in && !done_q
            |=> !done_q && $stable(res_q))
        else $error("abort set done flag");
    a_zero_off: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        wr_in && addr_in == ADCSC_ADDR_CTRL && wdata_in == 8'h0
            && !sleep_in && !wake_in |=> !conv_on_out && !ctrl_q[CTRL_GO])
        else $error("zero write left converter on");
    a_wake_ans: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        wake_in |=> ans_q == ANS_RESET && ctrl_q == CTRL_RESET)
        else $error("wake defaults missing");
    sequence s_first_tick;
        busy && tick && nsh_q == 4'h0 && ctrl_d[CTRL_GO]
            && !sleep_in && !wake_in;
    endsequence
    a_lead_one: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        s_first_tick |=> res_q[$left(res_q)])
        else $error("leading one missing after first shift");
    a_start_clears: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        $rose(busy) |-> res_q == 8'h0)
        else $error("result not cleared at start");
    a_sleep_keeps: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in)
        sleep_in && busy && !(wr_in && addr_in == ADCSC_ADDR_RES)
            |=> $stable(res_q))
        else $error("sleep abort changed partial result");
endmodule // adcsc_top
`default_nettype wire

// ### tb/adcsc_analog.sv
`default_nettype none
module adcsc_analog (
    // Selected channel
    input  wire logic [3:0]  chan_in,
    input  wire logic [15:0] level_in,
    // Comparator
    output logic             comp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Steady level per channel over a whole conversion
    assign comp_out = level_in[chan_in];
endmodule // adcsc_analog
`default_nettype wire

// ### tb/test_adcsc_top.sv
`default_nettype none
module test_adcsc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsc_pkg::*;
    logic        ref_clk_in = 0, reset_n_in = 0, wr = 0, rd = 0;
    logic        sleep = 0, wake = 0, osc = 0, comp, on, irq, mask;
    logic [1:0]  addr = 0, cs;
    logic [7:0]  wdata = 0, rdata, r, r2, analog_pin_select;
    logic [3:0]  chan;
    logic [15:0] lvl = 0;
    integer      failures = 0, num_checks = 0, seed = 32'ha516;
    integer      cyc = 0, oc = 0, t0, p, k, i;

    always #10 ref_clk_in = ~ref_clk_in;
    // Oscillator tick every third clock
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        oc <= (oc + 1) % 3;
        osc <= (oc == 0);
    end

    adcsc_top i_adcsc_top (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .sleep_in(sleep), .wake_in(wake),
        .osc_tick_in(osc), .comp_in(comp), .chan_out(chan), .ans_out(analog_pin_select),
        .conv_on_out(on), .irq_out(irq));
    adcsc_analog i_adcsc_analog (.chan_in(chan), .level_in(lvl),
        .comp_out(comp));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_span(input integer n, input integer lo, hi);
        num_checks++;
        if (n < lo || n > hi) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h..%h", $time, n, lo, hi);
        end
    endtask
    task automatic wr_r(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge ref_clk_in);
        wr <= 0;
        // Return once the write has settled in the registers
        #1;
    endtask
    task automatic rd_r(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1;
        @(posedge ref_clk_in);
        rd <= 0;
        #1 d = rdata;
    endtask
    task automatic end_of_test;
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(20 * 40000);
        failures++;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge ref_clk_in);
        reset_n_in <= 1;
        rd_r(ADCSC_ADDR_CTRL, r); chk(r, CTRL_RESET);
        rd_r(ADCSC_ADDR_ANS, r); chk(r, ANS_RESET);
        chk({4'h0, chan}, 8'h0f);
        chk({7'h0, on}, 8'h00);
        wr_r(ADCSC_ADDR_CTRL, 8'h02);
        rd_r(ADCSC_ADDR_CTRL, r); chk(r, 8'h00);
        for (k = 0; k < 4; k++) begin
            cs = 2'(k);
            mask = cs[0];
            lvl <= 16'($random(seed));
            p = (k == 3) ? 12 : (16 >> k);
            wr_r(ADCSC_ADDR_IRQ, {6'h0, mask, 1'b0});
            wr_r(ADCSC_ADDR_CTRL, {cs, 2'h0, cs, 2'h1});
            wr_r(ADCSC_ADDR_CTRL, {cs, 2'h0, cs, 2'h3});
            t0 = cyc;
            wr_r(ADCSC_ADDR_CTRL, {cs, 2'h1, cs, 2'h3});
            chk({4'h0, chan}, {6'h0, cs});
            r = 8'h02;
            for (i = 0; i < 300 && r[1]; i++)
                rd_r(ADCSC_ADDR_CTRL, r);
            chk_span(cyc - t0, 8 * p, 9 * p + 14);
            chk(r, {cs, 2'h1, cs, 2'h1});
            rd_r(ADCSC_ADDR_RES, r); chk(r, {8{lvl[k]}});
            chk({4'h0, chan}, {6'h1, cs});
            rd_r(ADCSC_ADDR_IRQ, r); chk(r, {6'h0, mask, 1'b1});
            chk({7'h0, irq}, {7'h0, mask});
            wr_r(ADCSC_ADDR_IRQ, {6'h0, mask, 1'b1});
            chk({7'h0, irq}, 8'h00);
        end
        // Software abort keeps the partial byte
        wr_r(ADCSC_ADDR_CTRL, 8'h03);
        repeat (60) @(posedge ref_clk_in);
        wr_r(ADCSC_ADDR_CTRL, 8'h01);
        rd_r(ADCSC_ADDR_RES, r);
        repeat (100) @(posedge ref_clk_in);
        rd_r(ADCSC_ADDR_RES, r2); chk(r2, r);
        rd_r(ADCSC_ADDR_IRQ, r); chk(r, 8'h02);
        // Sleep mid conversion
        wr_r(ADCSC_ADDR_ANS, 8'h5a);
        wr_r(ADCSC_ADDR_CTRL, 8'h07);
        repeat (60) @(posedge ref_clk_in);
        sleep <= 1;
        repeat (3) @(posedge ref_clk_in);
        rd_r(ADCSC_ADDR_CTRL, r); chk(r, 8'hfc);
        chk({7'h0, on}, 8'h00);
        chk({4'h0, chan}, 8'h0f);
        chk(analog_pin_select, 8'h5a);
        rd_r(ADCSC_ADDR_RES, r);
        wr_r(ADCSC_ADDR_CTRL, 8'h03);
        repeat (100) @(posedge ref_clk_in);
        rd_r(ADCSC_ADDR_RES, r2); chk(r2, r);
        rd_r(ADCSC_ADDR_IRQ, r); chk(r, 8'h02);
        @(posedge ref_clk_in);
        sleep <= 0;
        wake <= 1;
        @(posedge ref_clk_in);
        wake <= 0;
        rd_r(ADCSC_ADDR_CTRL, r); chk(r, 8'hfc);
        chk(analog_pin_select, 8'hff);
        wr_r(ADCSC_ADDR_CTRL, 8'h03);
        chk({7'h0, on}, 8'h01);
        wr_r(ADCSC_ADDR_CTRL, 8'h00);
        chk({7'h0, on}, 8'h00);
        rd_r(ADCSC_ADDR_CTRL, r); chk(r, 8'h00);
        end_of_test;
    end
endmodule // test_adcsc_top
`default_nettype wire
